// ===== design/acr_regs.v
// Configuration and channel register bank of the dual sampling converter,
// with readout sequencing of conversion words and the appended status word.
// Assumes an AXI4-Lite master on aclk and conversion results from logic on
// the same clock, delivered with a one-cycle conv_done pulse.
//
// Function
// - Oversampling field selects averaging ratio
// - Status disabled: readout gives conversions only
// - Status enabled: append status after conversions
// - Status only after all channels read
// - CRC sits in status low byte
// - CRC enable behaves like status enable
// - Channel register picks next conversion source
// - Channel B codes: inputs, supply, regulator
// - Self-test code returns 0x5555 for B
// - Bits 15..9 hold register address on direct writes; zero at reset, command bits 15..9 on command writes
// - Channel register at 0x03, reset zero
// - Command bit 15 writes, else reads
// - Stack bit clear, address 00011 selects channel
`timescale 1ns/1ps
`default_nettype none
`include "acr_regs_map.vh"
module acr_regs
#(
  parameter CONV_W = 16
)
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire conv_done,
  input wire [CONV_W-1:0] conv_a_data,
  input wire [CONV_W-1:0] conv_b_data,
  output reg [3:0] sample_chb_sel_reg,
  output reg sample_chb_valid_reg,
  output reg avg_enable_reg,
  output reg [7:0] avg_ratio_reg
);
  // Readout states, one-hot
  localparam RD_A = 4'b0001;
  localparam RD_B = 4'b0010;
  localparam RD_ST = 4'b0100;
  localparam RD_END = 4'b1000;

  reg [4:0] cfg_reg;
  reg [6:0] cfg_addrf_reg;
  reg [7:0] chan_reg;
  reg [6:0] chan_addrf_reg;
  reg [4:0] rd_target_reg;
  reg rd_target_ok_reg;
  reg [CONV_W-1:0] word_a_reg;
  reg [CONV_W-1:0] word_b_reg;
  reg [3:0] rd_state_reg;
  reg [3:0] rd_state_next;
  reg [7:0] aw_addr_reg;
  reg aw_full_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_full_reg;
  wire [7:0] crc_value;
  wire dec_avg_enable;
  wire [7:0] dec_avg_ratio;
  wire dec_chb_analog;
  wire dec_chb_selftest;
  wire status_on;
  wire wr_fire;
  wire rd_fire;
  wire [5:0] wr_idx;
  wire [5:0] rd_idx;
  wire [15:0] wr_word;
  wire [15:0] cfg_word;
  wire [15:0] chan_word;
  wire [15:0] status_word;
  wire cmd_write;
  wire [4:0] cmd_addr;
  reg [15:0] result_word;
  reg [31:0] rd_data;
  reg rd_hit;
  reg rd_pop;

  // Either enable bit turns on the status-and-CRC append
  assign status_on = cfg_reg[`ACR_STATUS_EN_BIT] |
    cfg_reg[`ACR_CRC_EN_BIT];

  acr_decode u_decode
  (
    .os_sel(cfg_reg[`ACR_OS_HI:`ACR_OS_LO]),
    .chb_sel(chan_reg[`ACR_CHB_HI:`ACR_CHB_LO]),
    .avg_enable(dec_avg_enable),
    .avg_ratio(dec_avg_ratio),
    .chb_analog(dec_chb_analog),
    .chb_selftest(dec_chb_selftest)
  );

  // CRC runs over the captured A and B words of each conversion
  acr_crc8 #(.DATA_W(2 * CONV_W)) u_crc
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(conv_done),
    .update(conv_done),
    .data({conv_a_data, conv_b_data}),
    .crc_reg(crc_value)
  );

  // AXI write channels are taken independently, one of each held
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_idx = aw_addr_reg[7:2];
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid;
  assign rd_idx = s_axi_araddr[7:2];

  // Passes a lane or zero depending on its strobe
  function [7:0] s_axi_wstrb_m;
    input en;
    input [7:0] d;
    begin
      s_axi_wstrb_m = en ? d : 8'h00;
    end
  endfunction

  // Low 16 bits of write data after byte-lane masking
  assign wr_word = {s_axi_wstrb_m(w_strb_reg[1], w_data_reg[15:8]),
    s_axi_wstrb_m(w_strb_reg[0], w_data_reg[7:0])};

  // Register words as read back, bit 8 and unused fields read zero
  assign cfg_word = {cfg_addrf_reg, 1'b0, 3'h0, cfg_reg};
  assign chan_word = {chan_addrf_reg, 1'b0, chan_reg};
  // Status word: settings on top, CRC in the low byte
  assign status_word = {chan_reg[`ACR_CHB_HI:`ACR_CHB_LO],
    cfg_reg[`ACR_OS_HI:`ACR_OS_LO], 1'b0, crc_value};

  // Parallel-style command word fields
  assign cmd_write = wr_word[`ACR_CMD_WR_BIT];
  assign cmd_addr = wr_word[`ACR_CMD_ADDR_HI:`ACR_CMD_ADDR_LO];

  // Write address and data holding registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (wr_fire)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  // Register writes, direct and through the command word
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_reg <= `ACR_CFG_RESET;
      cfg_addrf_reg <= `ACR_ADDRF_RESET;
      chan_reg <= `ACR_CHAN_RESET;
      chan_addrf_reg <= `ACR_ADDRF_RESET;
      rd_target_reg <= `ACR_PADDR_RESULT;
      rd_target_ok_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACR_RESP_OKAY;
    end
    else
    begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `ACR_RESP_OKAY;
        if (wr_idx == `ACR_IDX_CFG)
        begin
          cfg_reg <= wr_word[`ACR_OS_HI:`ACR_CRC_EN_BIT];
          cfg_addrf_reg <= {2'b00, `ACR_PADDR_CFG};
        end
        else if (wr_idx == `ACR_IDX_CHAN)
        begin
          chan_reg <= wr_word[`ACR_CHB_HI:`ACR_CHA_LO];
          chan_addrf_reg <= {2'b00, `ACR_PADDR_CHAN};
        end
        else if (wr_idx == `ACR_IDX_PORT_CMD)
        begin
          if (!cmd_write)
          begin
            rd_target_reg <= cmd_addr;
            rd_target_ok_reg <= !wr_word[`ACR_CMD_STACK_BIT];
          end
          else if (!wr_word[`ACR_CMD_STACK_BIT] &&
            cmd_addr == `ACR_PADDR_CFG)
          begin
            cfg_reg <= wr_word[`ACR_OS_HI:`ACR_CRC_EN_BIT];
            cfg_addrf_reg <= wr_word[`ACR_ADDRF_HI:`ACR_ADDRF_LO];
          end
          else if (!wr_word[`ACR_CMD_STACK_BIT] &&
            cmd_addr == `ACR_PADDR_CHAN)
          begin
            chan_reg <= wr_word[`ACR_CHB_HI:`ACR_CHA_LO];
            chan_addrf_reg <= wr_word[`ACR_ADDRF_HI:`ACR_ADDRF_LO];
          end
        end
        else if (wr_idx != `ACR_IDX_PORT_DATA &&
          wr_idx != `ACR_IDX_STATE && wr_idx != `ACR_IDX_RESULT)
          s_axi_bresp <= `ACR_RESP_SLVERR;
      end
    end
  end

  // Word at the current readout position
  always @*
  begin
    case (rd_state_reg)
      RD_A: result_word = word_a_reg;
      RD_B: result_word = dec_chb_selftest ?
        `ACR_TEST_PATTERN_B : word_b_reg;
      RD_ST: result_word = status_word;
      default: result_word = 16'h0000;
    endcase
  end

  // Read decode and the readout pop it causes
  always @*
  begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    rd_pop = 1'b0;
    if (rd_idx == `ACR_IDX_CFG)
      rd_data = {16'h0000, cfg_word};
    else if (rd_idx == `ACR_IDX_CHAN)
      rd_data = {16'h0000, chan_word};
    else if (rd_idx == `ACR_IDX_PORT_CMD)
      rd_data = {16'h0000, 1'b0, !rd_target_ok_reg, rd_target_reg, 9'h000};
    else if (rd_idx == `ACR_IDX_PORT_DATA)
    begin
      if (rd_target_ok_reg && rd_target_reg == `ACR_PADDR_CFG)
        rd_data = {16'h0000, cfg_word};
      else if (rd_target_ok_reg && rd_target_reg == `ACR_PADDR_CHAN)
        rd_data = {16'h0000, chan_word};
      else if (rd_target_ok_reg && rd_target_reg == `ACR_PADDR_RESULT)
      begin
        rd_data = {16'h0000, result_word};
        rd_pop = 1'b1;
      end
    end
    else if (rd_idx == `ACR_IDX_STATE)
      rd_data = {16'h0000, rd_state_reg, avg_enable_reg, status_on,
        2'b00, avg_ratio_reg};
    else if (rd_idx == `ACR_IDX_RESULT)
    begin
      rd_data = {16'h0000, result_word};
      rd_pop = 1'b1;
    end
    else
      rd_hit = 1'b0;
  end

  // Read data channel
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ACR_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? `ACR_RESP_OKAY : `ACR_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Readout sequence: A, B, then status only if enabled and all read
  always @*
  begin
    rd_state_next = rd_state_reg;
    if (rd_fire && rd_pop)
    begin
      case (rd_state_reg)
        RD_A: rd_state_next = RD_B;
        RD_B: rd_state_next = status_on ? RD_ST : RD_END;
        RD_ST: rd_state_next = RD_END;
        default: rd_state_next = RD_END;
      endcase
    end
    if (conv_done)
      rd_state_next = RD_A;
  end

  // Captured conversion words and readout state
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state_reg <= RD_END;
      word_a_reg <= {CONV_W{1'b0}};
      word_b_reg <= {CONV_W{1'b0}};
    end
    else
    begin
      rd_state_reg <= rd_state_next;
      if (conv_done)
      begin
        word_a_reg <= conv_a_data;
        word_b_reg <= conv_b_data;
      end
    end
  end

  // Settings handed to the converter for the next conversion
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sample_chb_sel_reg <= 4'h0;
      sample_chb_valid_reg <= 1'b0;
      avg_enable_reg <= 1'b0;
      avg_ratio_reg <= 8'h01;
    end
    else
    begin
      sample_chb_sel_reg <= chan_reg[`ACR_CHB_HI:`ACR_CHB_LO];
      sample_chb_valid_reg <= dec_chb_analog;
      avg_enable_reg <= dec_avg_enable;
      avg_ratio_reg <= dec_avg_ratio;
    end
  end
endmodule // acr_regs
`default_nettype wire

// ===== include/acr_regs_map.vh
// Constants for the converter configuration and channel register bank.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
`ifndef ACR_REGS_MAP_VH
`define ACR_REGS_MAP_VH
// Register indices, byte address is four times the index
`define ACR_IDX_CFG 6'h02
`define ACR_IDX_CHAN 6'h03
`define ACR_IDX_PORT_CMD 6'h10
`define ACR_IDX_PORT_DATA 6'h11
`define ACR_IDX_STATE 6'h12
`define ACR_IDX_RESULT 6'h13
// Register addresses seen on the parallel command word
`define ACR_PADDR_RESULT 5'h00
`define ACR_PADDR_CFG 5'h02
`define ACR_PADDR_CHAN 5'h03
// Parallel command word layout
`define ACR_CMD_WR_BIT 15
`define ACR_CMD_STACK_BIT 14
`define ACR_CMD_ADDR_HI 13
`define ACR_CMD_ADDR_LO 9
`define ACR_CMD_DATA_HI 8
// Register word layout
`define ACR_ADDRF_HI 15
`define ACR_ADDRF_LO 9
`define ACR_RSVD_BIT 8
`define ACR_OS_HI 4
`define ACR_OS_LO 2
`define ACR_STATUS_EN_BIT 1
`define ACR_CRC_EN_BIT 0
`define ACR_CHB_HI 7
`define ACR_CHB_LO 4
`define ACR_CHA_HI 3
`define ACR_CHA_LO 0
// Reset values
`define ACR_CFG_RESET 5'h00
`define ACR_CHAN_RESET 8'h00
`define ACR_ADDRF_RESET 7'h00
// Channel B codes
`define ACR_CHB_LAST_INPUT 4'h7
`define ACR_CHB_SUPPLY 4'h8
`define ACR_CHB_REGULATOR 4'h9
`define ACR_CHB_SELFTEST 4'hb
`define ACR_TEST_PATTERN_B 16'h5555
// CRC
`define ACR_CRC_POLY 8'h07
`define ACR_CRC_INIT 8'h00
// AXI responses
`define ACR_RESP_OKAY 2'b00
`define ACR_RESP_SLVERR 2'b10
`endif

// ===== design/acr_crc8.v
// CRC-8 over one data word per update, registered result.
// Assumes clear and update come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "acr_regs_map.vh"
module acr_crc8
#(
  parameter DATA_W = 32
)
(
  input wire aclk,
  input wire aresetn,
  input wire clear,
  input wire update,
  input wire [DATA_W-1:0] data,
  output reg [7:0] crc_reg
);
  reg [7:0] crc_next;
  reg [7:0] c;
  integer i;

  // Bit-serial division unrolled over the word, MSB first; a clear
  // restarts from the initial value so conversions never chain
  always @*
  begin
    c = clear ? `ACR_CRC_INIT : crc_reg;
    for (i = DATA_W - 1; i >= 0; i = i - 1)
    begin
      if (c[7] ^ data[i])
        c = {c[6:0], 1'b0} ^ `ACR_CRC_POLY;
      else
        c = {c[6:0], 1'b0};
    end
    crc_next = crc_reg;
    if (clear && update)
      crc_next = c;
    else if (clear)
      crc_next = `ACR_CRC_INIT;
    else if (update)
      crc_next = c;
  end

  // Result register
  always @(posedge aclk)
  begin
    if (!aresetn)
      crc_reg <= `ACR_CRC_INIT;
    else
      crc_reg <= crc_next;
  end
endmodule // acr_crc8
`default_nettype wire

// ===== design/acr_decode.v
// Decodes the oversampling field and the converter B channel field.
// Purely combinational; the caller registers all results except chb_selftest.
`timescale 1ns/1ps
`default_nettype none
`include "acr_regs_map.vh"
module acr_decode
(
  input wire [2:0] os_sel,
  input wire [3:0] chb_sel,
  output wire avg_enable,
  output wire [7:0] avg_ratio,
  output wire chb_analog,
  output wire chb_selftest
);
  // Zero disables averaging, otherwise ratio is two to the code
  assign avg_enable = (os_sel != 3'h0);
  assign avg_ratio = 8'h01 << os_sel;

  // Inputs, supply and regulator monitor are real samples
  assign chb_analog = (chb_sel <= `ACR_CHB_REGULATOR);
  assign chb_selftest = (chb_sel == `ACR_CHB_SELFTEST);
endmodule // acr_decode
`default_nettype wire

// ===== tb/acr_regs_asserts.sv
// Checker for the register bank top ports.
// Assumes one clock aclk and synchronous active-low aresetn.
`timescale 1ns/1ps
`default_nettype none
module acr_regs_chk
(
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [3:0] sample_chb_sel_reg,
  input wire sample_chb_valid_reg,
  input wire avg_enable_reg,
  input wire [7:0] avg_ratio_reg
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Handshake holding and refusal
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_rd_refuse: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  // Decode of the oversampling field
  chk_ratio_pow: assert property ($onehot(avg_ratio_reg))
    else $error("ratio not a power of two");
  chk_avg_enable: assert property (avg_enable_reg == (avg_ratio_reg != 8'h01))
    else $error("averaging enable mismatch");
  // Channel B decode and update cause
  chk_chb_valid: assert property ($past(aresetn) && $stable(sample_chb_sel_reg)
    |-> sample_chb_valid_reg == (sample_chb_sel_reg <= 4'h9))
    else $error("channel valid mismatch");
  chk_sel_cause: assert property ($changed(sample_chb_sel_reg) |-> $past(s_axi_bvalid))
    else $error("channel changed without write");
  chk_reset_vals: assert property ($rose(aresetn) |-> sample_chb_sel_reg == 4'h0
    && avg_ratio_reg == 8'h01 && !avg_enable_reg)
    else $error("reset values wrong");
  cov_wr: cover property (s_axi_bvalid && s_axi_bready);
  cov_rd: cover property (s_axi_rvalid && !s_axi_rready);
  cov_selftest: cover property (sample_chb_sel_reg == 4'hb);
endmodule // acr_regs_chk
`default_nettype wire

// ===== tb/acr_conv_model.sv
// Converter result source: pulses done with the A and B words.
// Assumes fire comes from the bench on aclk edges.
`timescale 1ns/1ps
`default_nettype none
module acr_conv_model
(
  input wire logic aclk,
  input wire logic fire,
  input wire logic [15:0] a_in,
  input wire logic [15:0] b_in,
  output var logic done,
  output var logic [15:0] a_out,
  output var logic [15:0] b_out
);
  // Words are meaningful only with done; otherwise they toggle
  always @(posedge aclk)
  begin
    done <= fire;
    a_out <= fire ? a_in : ~a_out;
    b_out <= fire ? b_in : ~b_out;
  end
endmodule // acr_conv_model
`default_nettype wire

// ===== tb/tb_acr_regs.sv
// Self-checking bench for the register bank over AXI4-Lite.
// Assumes acr_regs, acr_conv_model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_acr_regs;
  logic aclk = 0, aresetn = 0, fire = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [15:0] ma = 0, mb = 0, a, b;
  logic [3:0] c;
  logic [4:0] cf;
  logic [7:0] ra;
  wire awready, wready, bvalid, arready, rvalid, done, sval, aen;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] ca, cb;
  wire [3:0] sel;
  wire [7:0] ratio;
  integer errors = 0, tests_run = 0, cyc = 0, i;
  // Clock of 100 ns
  always #50 aclk = ~aclk;
  acr_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .conv_done(done), .conv_a_data(ca),
    .conv_b_data(cb), .sample_chb_sel_reg(sel), .sample_chb_valid_reg(sval),
    .avg_enable_reg(aen), .avg_ratio_reg(ratio));
  acr_conv_model u_conv (.aclk(aclk), .fire(fire), .a_in(ma), .b_in(mb),
    .done(done), .a_out(ca), .b_out(cb));
  task end_of_test;
    if (errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      end_of_test;
    end
  end
  task cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Write with optional response stall, then check response
  task wr(input logic [7:0] ad, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= ad; wdata <= v; awvalid <= 1; wvalid <= 1;
    bready <= $urandom % 2;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1;
    end
    bready <= 0;
    cmp({30'h0, bresp}, {30'h0, er});
  endtask
  // Read with optional stall, then check data and response
  task rc(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= ad; arvalid <= 1; rready <= $urandom % 2;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1;
    end
    rready <= 0;
    cmp(rdata, e);
    cmp({30'h0, rresp}, {30'h0, er});
  endtask
  // Register word: address field, zero reserved bit, data byte
  function automatic logic [31:0] rw(input logic [6:0] f, input logic [7:0] v);
    rw = {16'h0, f, 1'b0, v};
  endfunction
  function automatic logic [7:0] crc8(input logic [31:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 31; k >= 0; k--)
      r = {r[6:0], 1'b0} ^ ((r[7] ^ v[k]) ? 8'h07 : 8'h00);
    crc8 = r;
  endfunction
  initial
  begin
    void'($urandom(47));
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rc(8'h08, 0, 0);
    rc(8'h0c, 0, 0);
    // Every channel B code, random bit 8
    for (i = 0; i < 16; i++)
    begin
      d = $urandom; d[7:4] = i;
      wr(8'h0c, d, 0);
      repeat (2) @(posedge aclk);
      cmp({28'h0, sel}, i);
      cmp({31'h0, sval}, i < 10);
      rc(8'h0c, rw(7'h03, d[7:0]), 0);
    end
    // Every oversampling code
    for (i = 0; i < 8; i++)
    begin
      d = $urandom; d[4:2] = i;
      wr(8'h08, d, 0);
      repeat (2) @(posedge aclk);
      cmp({24'h0, ratio}, 1 << i);
      cmp({31'h0, aen}, i != 0);
      rc(8'h08, rw(7'h02, {3'h0, d[4:0]}), 0);
    end
    // Readouts across the append enables, self-test first
    for (i = 0; i < 8; i++)
    begin
      c = (i < 4) ? 4'hb : $urandom % 10;
      cf = {3'($urandom), 2'(i)};
      wr(8'h0c, {24'h0, c, 4'h0}, 0);
      wr(8'h08, {27'h0, cf}, 0);
      wr(8'h40, 32'h0, 0);
      ra = i[0] ? 8'h44 : 8'h4c;
      a = $urandom; b = $urandom;
      fire <= 1; ma <= a; mb <= b;
      @(posedge aclk);
      fire <= 0;
      repeat (3) @(posedge aclk);
      rc(ra, {16'h0, a}, 0);
      rc(ra, {16'h0, (c == 4'hb) ? 16'h5555 : b}, 0);
      if (cf[1:0] != 0)
        rc(ra, {16'h0, c, cf[4:2], 1'b0, crc8({a, b})}, 0);
      rc(ra, 0, 0);
      rc(8'h48, {16'h0, 4'h8, cf[4:2] != 0, cf[1:0] != 0, 2'b00,
        8'h01 << cf[4:2]}, 0);
    end
    // Command word path
    d = $urandom;
    wr(8'h40, {16'h0, 7'h43, d[8:0]}, 0);
    rc(8'h0c, rw(7'h43, d[7:0]), 0);
    wr(8'h40, {16'h0, 7'h42, d[8:0]}, 0);
    rc(8'h08, rw(7'h42, {3'h0, d[4:0]}), 0);
    wr(8'h40, 32'h0000_0600, 0);
    rc(8'h44, rw(7'h43, d[7:0]), 0);
    wr(8'h40, 32'h0000_4600, 0);
    rc(8'h44, 0, 0);
    rc(8'h40, 32'h0000_4600, 0);
    // Unmapped place
    wr(8'h10, $urandom, 2'b10);
    rc(8'h10, 0, 2'b10);
    end_of_test;
  end
endmodule // tb_acr_regs
bind acr_regs acr_regs_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sample_chb_sel_reg(sample_chb_sel_reg),
  .sample_chb_valid_reg(sample_chb_valid_reg),
  .avg_enable_reg(avg_enable_reg), .avg_ratio_reg(avg_ratio_reg));
`default_nettype wire
